// ===== core/sccs_pkg.sv
// Package: register map, field layout and bus carrier types for the serial clock and select block
//
// Overview of operation
// - Serial clock is pclk over twice (divisor plus one)
// - Manual mode: selects follow select_lines writes only
// - Auto mode: select asserts on start, drops at end
// - Polarity bit zero means low active, one high
// - Manual: select_lines bit one drives output active
// - Auto: marked outputs active only during transfers
// - Start bit begins transfer, reads busy, self-clears
// - Register writes ignored while transfer in progress
package sccs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] CTRL_ADDR = 32'hfff86200;
    localparam logic [31:0] DIV_ADDR = 32'hfff86204;
    localparam logic [31:0] SSEL_ADDR = 32'hfff86208;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int DIV_W = 16;
    localparam int SEL_W = 2;
    localparam int CTRL_START_BIT = 0;
    localparam int SSEL_LINES_LSB = 0;
    localparam int SSEL_POL_BIT = 2;
    localparam int SSEL_AUTO_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
    localparam logic [SEL_W-1:0] LINES_RESET = 2'h0;
    localparam logic POL_RESET = 1'b0;
    localparam logic AUTO_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Bus carrier types
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } sccs_apb_req_t;

    typedef struct packed {
        logic [SEL_W-1:0] lines;
        logic polarity;
        logic auto_sel;
    } sccs_select_cfg_t;

endpackage

// ===== core/sccs_clkdiv.sv
// Serial clock divider: toggles the serial clock every divisor-plus-one pclk cycles while running
module sccs_clkdiv (
    input wire logic clk, // peripheral clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic run, // transfer in progress
    input wire logic [sccs_pkg::DIV_W-1:0] divisor, // programmed divisor
    output logic sclk, // serial clock, idles low
    output logic sclk_rise, // one-cycle pulse with each rising sclk edge
    output logic sclk_fall // one-cycle pulse with each falling sclk edge
);

    logic [sccs_pkg::DIV_W-1:0] cnt_ff;
    logic [sccs_pkg::DIV_W-1:0] nxt_cnt;
    logic sclk_ff;
    logic nxt_sclk;
    logic rise_ff;
    logic fall_ff;
    wire logic terminal;

    ////////////////////////////////////////////////////////////////////////////
    // terminal count toggle
    assign terminal = (cnt_ff == divisor);
    // half period of divisor plus one
    assign nxt_cnt = (!run || terminal) ? sccs_pkg::DIV_RESET : cnt_ff + 16'h0001;
    // Clock parks low between transfers so each frame starts from a known level
    assign nxt_sclk = run ? (sclk_ff ^ terminal) : 1'b0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= sccs_pkg::DIV_RESET;
            sclk_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            sclk_ff <= nxt_sclk;
            rise_ff <= nxt_sclk & ~sclk_ff;
            fall_ff <= ~nxt_sclk & sclk_ff;
        end
    end

    assign sclk = sclk_ff;
    assign sclk_rise = rise_ff;
    assign sclk_fall = fall_ff;

endmodule

// ===== core/sccs_top.sv
// Serial master clock divider and slave-select generator with APB register access
module sccs_top (
    input wire logic clk, // peripheral clock, 40 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire sccs_pkg::sccs_apb_req_t apb_req, // APB request from the master
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic xfer_done, // one-cycle pulse from the shift datapath: transfer finished
    output logic busy, // transfer in progress
    output logic serial_clock_out, // serial clock to the slaves
    output logic sclk_rise, // pulse at each rising serial clock edge
    output logic sclk_fall, // pulse at each falling serial clock edge
    output logic [sccs_pkg::SEL_W-1:0] slave_select_out // slave select lines
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [sccs_pkg::DIV_W-1:0] divisor_ff;
    logic [sccs_pkg::DIV_W-1:0] nxt_divisor;
    sccs_pkg::sccs_select_cfg_t sel_cfg_ff;
    sccs_pkg::sccs_select_cfg_t nxt_sel_cfg;
    logic busy_ff;
    logic nxt_busy;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [sccs_pkg::SEL_W-1:0] ss_ff;
    logic [sccs_pkg::SEL_W-1:0] nxt_ss;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire logic setup_phase;
    wire logic access_phase;
    wire logic hit_ctrl;
    wire logic hit_div;
    wire logic hit_ssel;
    wire logic hit_any;
    wire logic wr_ok;
    wire logic wr_ctrl;
    wire logic wr_div;
    wire logic wr_ssel;
    wire logic rd_any;
    wire logic start_req;

    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign access_phase = apb_req.psel & apb_req.penable;
    assign hit_ctrl = (apb_req.paddr == sccs_pkg::CTRL_ADDR);
    assign hit_div = (apb_req.paddr == sccs_pkg::DIV_ADDR);
    assign hit_ssel = (apb_req.paddr == sccs_pkg::SSEL_ADDR);
    assign hit_any = hit_ctrl | hit_div | hit_ssel;

    assign wr_ok = access_phase & apb_req.pwrite & hit_any & ~busy_ff;
    assign wr_ctrl = wr_ok & hit_ctrl;
    assign wr_div = wr_ok & hit_div;
    assign wr_ssel = wr_ok & hit_ssel;

    // Read data is captured in setup so it is already in a flop during access
    assign rd_any = setup_phase & ~apb_req.pwrite;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase & ~hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer control

    assign start_req = wr_ctrl & apb_req.pwdata[sccs_pkg::CTRL_START_BIT];

    // busy clears when the datapath reports the end
    assign nxt_busy = start_req ? 1'b1 : (xfer_done ? 1'b0 : busy_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration updates

    assign nxt_divisor = wr_div ? apb_req.pwdata[sccs_pkg::DIV_W-1:0] : divisor_ff;

    always_comb begin
        nxt_sel_cfg = sel_cfg_ff;
        if (wr_ssel) begin
            nxt_sel_cfg.lines = apb_req.pwdata[sccs_pkg::SSEL_LINES_LSB +: sccs_pkg::SEL_W];
            nxt_sel_cfg.polarity = apb_req.pwdata[sccs_pkg::SSEL_POL_BIT];
            nxt_sel_cfg.auto_sel = apb_req.pwdata[sccs_pkg::SSEL_AUTO_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    wire logic [31:0] rd_ctrl_word;
    wire logic [31:0] rd_div_word;
    wire logic [31:0] rd_ssel_word;
    wire logic [31:0] rd_word;

    // start bit reads back as busy
    assign rd_ctrl_word = {31'h00000000, busy_ff};
    assign rd_div_word = {16'h0000, divisor_ff};
    assign rd_ssel_word = {28'h0000000, sel_cfg_ff.auto_sel, sel_cfg_ff.polarity, sel_cfg_ff.lines};
    assign rd_word = hit_ctrl ? rd_ctrl_word :
                     hit_div ? rd_div_word :
                     hit_ssel ? rd_ssel_word : sccs_pkg::RDATA_RESET;
    assign nxt_prdata = rd_any ? rd_word : prdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Slave select generation

    wire logic [sccs_pkg::SEL_W-1:0] sel_active;
    wire logic [sccs_pkg::SEL_W-1:0] sel_manual;
    wire logic [sccs_pkg::SEL_W-1:0] sel_auto;

    // a one drives the line active
    assign sel_manual = sel_cfg_ff.lines;

    // asserted with the start, released at the end
    // marked lines active only while busy
    assign sel_auto = sel_cfg_ff.lines & {sccs_pkg::SEL_W{nxt_busy}};

    assign sel_active = sel_cfg_ff.auto_sel ? sel_auto : sel_manual;

    assign nxt_ss = sel_cfg_ff.polarity ? sel_active : ~sel_active;

    // one slave at a time is left to software: several set bits all assert
    // software must set the select before the start in manual mode

    ////////////////////////////////////////////////////////////////////////////
    // Flops

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divisor_ff <= sccs_pkg::DIV_RESET;
            sel_cfg_ff <= '{lines: sccs_pkg::LINES_RESET, polarity: sccs_pkg::POL_RESET,
                            auto_sel: sccs_pkg::AUTO_RESET};
            busy_ff <= 1'b0;
            prdata_ff <= sccs_pkg::RDATA_RESET;
        end else begin
            divisor_ff <= nxt_divisor;
            sel_cfg_ff <= nxt_sel_cfg;
            busy_ff <= nxt_busy;
            prdata_ff <= nxt_prdata;
        end
    end

    // Reset leaves polarity low-active, so every line idles high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_ff <= {sccs_pkg::SEL_W{1'b1}};
        end else begin
            ss_ff <= nxt_ss;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock

    // divider runs only during a transfer
    // a zero divisor still works, giving pclk over two
    // Fed from the next busy value so the clock parks low at the very edge that ends the transfer
    sccs_clkdiv u_clkdiv (
        .clk(clk),
        .rst(rst),
        .run(nxt_busy),
        .divisor(divisor_ff),
        .sclk(serial_clock_out),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall)
    );

    assign prdata = prdata_ff;
    assign busy = busy_ff;
    assign slave_select_out = ss_ff;

endmodule

// ===== verification/sccs_checker.sv
// Checker: timing relations between start, busy, serial clock and selects
module sccs_checker (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire sccs_pkg::sccs_apb_req_t apb_req, // bus request
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic xfer_done, // end pulse
    input wire logic busy, // busy
    input wire logic serial_clock_out, // serial clock
    input wire logic sclk_rise, // rise pulse
    input wire logic sclk_fall, // fall pulse
    input wire logic [sccs_pkg::SEL_W-1:0] slave_select_out // selects
);
    timeunit 1ns;
    timeprecision 1ps;
    wire wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire go = wr && apb_req.paddr == sccs_pkg::CTRL_ADDR && apb_req.pwdata[0];
    wire ssw = wr && apb_req.paddr == sccs_pkg::SSEL_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_start_busy: assert property (go && !busy |=> busy)
        else $error("start ignored");
    chk_busy_hold: assert property (busy && !xfer_done |=> busy)
        else $error("busy dropped early");
    chk_busy_end: assert property (busy && xfer_done |=> !busy)
        else $error("busy stuck");
    chk_idle_stay: assert property (!busy && !go |=> !busy)
        else $error("busy without start");
    chk_sclk_idle: assert property (!busy |-> !serial_clock_out)
        else $error("serial clock runs idle");
    chk_rise_pulse: assert property ($rose(serial_clock_out) |-> sclk_rise)
        else $error("rise pulse missing");
    chk_fall_pulse: assert property ($fell(serial_clock_out) |-> sclk_fall)
        else $error("fall pulse missing");
    chk_sel_cause: assert property ($changed(slave_select_out) |-> $past(ssw, 2) || $changed(busy))
        else $error("select moved without cause");
    chk_sel_lock: assert property (busy && $past(busy) |-> $stable(slave_select_out))
        else $error("select moved in transfer");
endmodule

bind sccs_top sccs_checker u_chk (.clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xfer_done(xfer_done), .busy(busy),
    .serial_clock_out(serial_clock_out), .sclk_rise(sclk_rise), .sclk_fall(sclk_fall),
    .slave_select_out(slave_select_out));

// ===== verification/sccs_slave_model.sv
// Serial slave model: counts serial clock rises while its select is active
module sccs_slave_model #(parameter logic ACT = 1'b0) (
    input wire logic clk, // peripheral clock
    input wire logic sclk, // serial clock
    input wire logic ss, // own select line
    output int n_rise, // rises seen while selected
    output int gap // pclk cycles between last two rises
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int last = 0;
    int rises = 0;
    int spacing = 0;
    logic sclk_d = 1'b0;
    assign n_rise = rises;
    assign gap = spacing;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sclk_d <= sclk;
        if (sclk && !sclk_d && ss == ACT) begin
            rises <= rises + 1;
            spacing <= cyc - last;
            last <= cyc;
        end
    end
endmodule

// ===== verification/tb_top.sv
// Testbench: register access, manual and automatic select, serial clock rate
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] AC = sccs_pkg::CTRL_ADDR;
    localparam logic [31:0] AD = sccs_pkg::DIV_ADDR;
    localparam logic [31:0] AS = sccs_pkg::SSEL_ADDR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic xfer_done = 1'b0;
    sccs_pkg::sccs_apb_req_t req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, busy, sclk;
    logic [1:0] ss;
    int n_fail = 0;
    int n_tests = 0;
    int n_rise, gap;
    always #12.5 clk = ~clk;
    sccs_top u_dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_done(xfer_done), .busy(busy), .serial_clock_out(sclk),
        .sclk_rise(), .sclk_fall(), .slave_select_out(ss));
    sccs_slave_model u_slv (.clk(clk), .sclk(sclk), .ss(ss[1]), .n_rise(n_rise), .gap(gap));
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Holds the request until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp(nm, exp, rd);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle end pulse, as the shift datapath gives it
    task automatic end_xfer;
        @(posedge clk);
        xfer_done <= 1'b1;
        @(posedge clk);
        xfer_done <= 1'b0;
        #1;
    endtask
    task automatic complete_run;
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc("div_rst", AD, 32'h0);
        rdc("ssel_rst", AS, 32'h0);
        cmp("ss_rst", 32'h3, ss);
        xfer(1'b0, 32'hfff8620c, 32'h0);
        cmp("unmapped_err", 32'h1, err);
        xfer(1'b1, AS, 32'h1);
        tick(1);
        cmp("ss_manual", 32'h2, ss);
        xfer(1'b1, AS, 32'h5);
        tick(1);
        cmp("ss_pol_high", 32'h1, ss);
        xfer(1'b1, AS, 32'h4);
        tick(1);
        cmp("ss_release", 32'h0, ss);
        xfer(1'b1, AD, 32'h12345);
        rdc("div_mask", AD, 32'h2345);
        xfer(1'b1, AD, 32'h2);
        xfer(1'b1, AS, 32'ha);
        tick(1);
        cmp("ss_auto_idle", 32'h3, ss);
        xfer(1'b1, AC, 32'h1);
        #1;
        cmp("busy_go", 32'h1, busy);
        cmp("ss_auto_on", 32'h1, ss);
        rdc("ctrl_busy", AC, 32'h1);
        xfer(1'b1, AD, 32'h7);
        xfer(1'b1, AS, 32'h0);
        for (int i = 0; i < 200 && n_rise < 3; i++) tick(1);
        cmp("sclk_gap", 32'h6, gap);
        end_xfer();
        cmp("busy_end", 32'h0, busy);
        cmp("ss_auto_off", 32'h3, ss);
        cmp("sclk_idle", 32'h0, sclk);
        rdc("div_kept", AD, 32'h2);
        rdc("ssel_kept", AS, 32'ha);
        xfer(1'b1, AC, 32'h0);
        tick(1);
        cmp("no_go", 32'h0, busy);
        xfer(1'b1, AS, 32'h2);
        xfer(1'b1, AC, 32'h1);
        #1;
        cmp("ss_man_go", 32'h1, ss);
        end_xfer();
        cmp("ss_man_end", 32'h1, ss);
        xfer(1'b1, AS, 32'hd);
        tick(1);
        cmp("ss_hi_idle", 32'h0, ss);
        xfer(1'b1, AC, 32'h1);
        #1;
        cmp("ss_hi_on", 32'h1, ss);
        end_xfer();
        cmp("ss_hi_off", 32'h0, ss);
        cmp("sclk_hi_idle", 32'h0, sclk);
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
